// [tps_timer_prescaler.v]
// Shared timer prescaler, clock select, external clock sync and timer 0 flags
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tps_defines.vh"
module tps_timer_prescaler #(
  parameter PRE_W = `TPS_PRE_W
) (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_timer_clock_pin0,
  input  wire        ext_timer_clock_pin1,
  input  wire        cpu_status_word_ie,
  input  wire        ovf0_vector_ack,
  input  wire        cmp0_vector_ack,
  output wire        ovf0_irq,
  output wire        cmp0_irq,
  output reg         timer1_tick,
  output reg         timer3_tick,
  output wire        timer3_available,
  output reg  [7:0]  timer0_count
);

  // AXI4-Lite write capture
  reg        aw_held;
  reg        w_held;
  reg [5:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire [5:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire        wr_fire = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                        (w_held || (s_axi_wvalid && s_axi_wready));
  wire        wr_lane0 = wr_fire && wr_strb[0];
  wire        wr_map  = (wr_addr == `TPS_OFS_FLAGS) || (wr_addr == `TPS_OFS_MASK) ||
                        (wr_addr == `TPS_OFS_SFC) || (wr_addr == `TPS_OFS_CSEL) ||
                        (wr_addr == `TPS_OFS_T0CTRL) || (wr_addr == `TPS_OFS_T0CNT);

  // Registers
  reg [7:0]  timer_interrupt_mask;
  reg        timer_sync_hold;
  reg        compat_mode;
  reg        shared_prescaler_reset;
  reg        async_prescaler_reset;
  reg [2:0]  clock_select_field0;
  reg [2:0]  clock_select_field1;
  reg [2:0]  clock_select_field3;
  reg [7:0]  cmp0_value;
  reg [1:0]  wgm0;
  reg        ovf0_flag;
  reg        cmp0_flag;
  reg        count_down;
  reg [PRE_W-1:0] prescaler;

  wire cmp0_irq_enable = timer_interrupt_mask[`TPS_BIT_CMP0];
  wire ovf0_irq_enable = timer_interrupt_mask[`TPS_BIT_OVF0];
  wire sfc_wr   = wr_lane0 && (wr_addr == `TPS_OFS_SFC);
  wire flags_wr = wr_lane0 && (wr_addr == `TPS_OFS_FLAGS);
  wire cnt_wr   = wr_lane0 && (wr_addr == `TPS_OFS_T0CNT);

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPS_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      timer_interrupt_mask <= 8'h00;
      timer_sync_hold <= 1'b0;
      compat_mode <= 1'b0;
      shared_prescaler_reset <= 1'b0;
      async_prescaler_reset <= 1'b0;
      clock_select_field0 <= `TPS_CS_STOP;
      clock_select_field1 <= `TPS_CS_STOP;
      clock_select_field3 <= `TPS_CS_STOP;
      cmp0_value <= 8'h00;
      wgm0 <= `TPS_WGM_NORMAL;
    end
    else
    begin
      if (wr_lane0 && wr_addr == `TPS_OFS_MASK)
        timer_interrupt_mask <= wr_data[7:0];
      if (sfc_wr)
      begin
        timer_sync_hold <= wr_data[`TPS_BIT_SYNC_HOLD];
        compat_mode <= wr_data[`TPS_BIT_COMPAT];
        if (wr_data[`TPS_BIT_SYNC_HOLD])
        begin
          shared_prescaler_reset <= wr_data[`TPS_BIT_PSR_SHARED];
          async_prescaler_reset <= wr_data[`TPS_BIT_PSR_ASYNC];
        end
        else
        begin
          // One-cycle pulse on write; cleared next cycle
          shared_prescaler_reset <= wr_data[`TPS_BIT_PSR_SHARED];
          async_prescaler_reset <= wr_data[`TPS_BIT_PSR_ASYNC];
        end
      end
      else if (!timer_sync_hold)
      begin
        shared_prescaler_reset <= 1'b0;
        async_prescaler_reset <= 1'b0;
      end
      if (wr_lane0 && wr_addr == `TPS_OFS_CSEL)
      begin
        clock_select_field0 <= wr_data[2:0];
        clock_select_field1 <= wr_data[6:4];
        clock_select_field3 <= wr_data[10:8];
      end
      if (wr_lane0 && wr_addr == `TPS_OFS_T0CTRL)
      begin
        cmp0_value <= wr_data[7:0];
        wgm0 <= wr_data[9:8];
      end
    end
  end

  // Free-running shared prescaler
  always @(posedge ref_clk)
  begin
    if (!rstn)
      prescaler <= {PRE_W{1'b0}};
    else if (shared_prescaler_reset)
      prescaler <= {PRE_W{1'b0}};
    else
      prescaler <= prescaler + {{(PRE_W-1){1'b0}}, 1'b1};
  end

  // Taps fire while the low bits are all ones, the cycle before they roll over to zero
  wire tap8    = (prescaler[2:0] == 3'h7);
  wire tap16   = (prescaler[3:0] == 4'hf);
  wire tap32   = (prescaler[4:0] == 5'h1f);
  wire tap64   = (prescaler[5:0] == 6'h3f);
  wire tap256  = (prescaler[7:0] == 8'hff);
  wire tap1024 = (prescaler[9:0] == 10'h3ff);

  // Pin held as the clock falls, as a latch open while high; then three flops
  reg [1:0] pin_latch;
  reg [1:0] sync1;
  reg [1:0] sync2;
  reg [1:0] sync3;
  wire [1:0] pin_in = {ext_timer_clock_pin1, ext_timer_clock_pin0};
  always @(negedge ref_clk)
    pin_latch <= pin_in;
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
    end
    else
    begin
      sync1 <= pin_latch;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  wire [1:0] ext_rise = sync2 & ~sync3;
  wire [1:0] ext_fall = ~sync2 & sync3;

  // Clock select per timer
  function tick_sel;
    input [2:0] cs;
    input       rise;
    input       fall;
    input       is_t3;
    begin
      case (cs)
        `TPS_CS_STOP:     tick_sel = 1'b0;
        `TPS_CS_DIRECT:   tick_sel = 1'b1;
        `TPS_CS_DIV8:     tick_sel = tap8;
        `TPS_CS_DIV64:    tick_sel = tap64;
        `TPS_CS_DIV256:   tick_sel = tap256;
        `TPS_CS_DIV1024:  tick_sel = tap1024;
        `TPS_CS_EXT_FALL: tick_sel = is_t3 ? tap16 : fall;
        `TPS_CS_EXT_RISE: tick_sel = is_t3 ? tap32 : rise;
        default:          tick_sel = 1'b0;
      endcase
    end
  endfunction

  wire halt_psc = shared_prescaler_reset;
  wire t0_tick  = !halt_psc && tick_sel(clock_select_field0, ext_rise[0], ext_fall[0], 1'b0);
  wire t1_tick  = !halt_psc && tick_sel(clock_select_field1, ext_rise[1], ext_fall[1], 1'b0);
  wire t3_tick  = !halt_psc && !compat_mode &&
                  tick_sel(clock_select_field3, 1'b0, 1'b0, 1'b1);
  assign timer3_available = !compat_mode;

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      timer1_tick <= 1'b0;
      timer3_tick <= 1'b0;
    end
    else
    begin
      timer1_tick <= t1_tick;
      timer3_tick <= t3_tick;
    end
  end

  // Timer 0 counter
  wire [7:0] top0 = (wgm0 == `TPS_WGM_CTC) ? cmp0_value : 8'hff;
  wire       match0 = (timer0_count == cmp0_value);
  reg  [7:0] next_count;
  reg        next_down;
  reg        ovf_event;
  always @*
  begin
    next_count = timer0_count;
    next_down = count_down;
    ovf_event = 1'b0;
    if (t0_tick)
    begin
      if (wgm0 == `TPS_WGM_PCPWM)
      begin
        if (!count_down && timer0_count == 8'hff)
        begin
          next_down = 1'b1;
          next_count = 8'hfe;
        end
        else if (count_down && timer0_count == 8'h00)
        begin
          next_down = 1'b0;
          next_count = 8'h01;
          ovf_event = 1'b1;
        end
        else
          next_count = count_down ? timer0_count - 8'h01 : timer0_count + 8'h01;
      end
      else if (timer0_count == top0)
      begin
        next_count = 8'h00;
        ovf_event = (wgm0 != `TPS_WGM_CTC) || (top0 == 8'hff);
      end
      else
        next_count = timer0_count + 8'h01;
    end
  end

  wire cmp_event = t0_tick && match0 && !cnt_wr;
  wire ovf_clr = ovf0_vector_ack || (flags_wr && wr_data[`TPS_BIT_OVF0]);
  wire cmp_clr = cmp0_vector_ack || (flags_wr && wr_data[`TPS_BIT_CMP0]);
  wire [7:0] flags_reset = `TPS_FLAGS_RESET;

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      timer0_count <= 8'h00;
      count_down <= 1'b0;
      ovf0_flag <= flags_reset[`TPS_BIT_OVF0];
      cmp0_flag <= flags_reset[`TPS_BIT_CMP0];
    end
    else
    begin
      timer0_count <= cnt_wr ? wr_data[7:0] : next_count;
      count_down <= next_down;
      if (ovf_event)
        ovf0_flag <= 1'b1;
      else if (ovf_clr)
        ovf0_flag <= 1'b0;
      if (cmp_event)
        cmp0_flag <= 1'b1;
      else if (cmp_clr)
        cmp0_flag <= 1'b0;
    end
  end

  assign cmp0_irq = cpu_status_word_ie && cmp0_irq_enable && cmp0_flag;
  assign ovf0_irq = cpu_status_word_ie && ovf0_irq_enable && ovf0_flag;

  // Read channel
  wire [7:0] timer_interrupt_flags = {6'h00, ovf0_flag, cmp0_flag};
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TPS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TPS_RESP_OKAY;
      case (s_axi_araddr)
        `TPS_OFS_FLAGS:  s_axi_rdata <= {24'h0, timer_interrupt_flags};
        `TPS_OFS_MASK:   s_axi_rdata <= {24'h0, timer_interrupt_mask};
        `TPS_OFS_SFC:    s_axi_rdata <= {24'h0, timer_sync_hold, compat_mode, 4'h0,
                                         async_prescaler_reset, shared_prescaler_reset};
        `TPS_OFS_CSEL:   s_axi_rdata <= {21'h0, clock_select_field3, 1'b0,
                                         clock_select_field1, 1'b0, clock_select_field0};
        `TPS_OFS_T0CTRL: s_axi_rdata <= {22'h0, wgm0, cmp0_value};
        `TPS_OFS_T0CNT:  s_axi_rdata <= {24'h0, timer0_count};
        `TPS_OFS_STATUS: s_axi_rdata <= {24'h0, count_down, sync2[1], sync2[0],
                                         prescaler[4:0]};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TPS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // tps_timer_prescaler

// [tps_defines.vh]
// Register offsets, field positions, reset values and code encodings for the timer prescaler
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH
`define TPS_ADDR_W          6
`define TPS_OFS_FLAGS       6'h00
`define TPS_OFS_MASK        6'h04
`define TPS_OFS_SFC         6'h08
`define TPS_OFS_CSEL        6'h0c
`define TPS_OFS_T0CTRL      6'h10
`define TPS_OFS_T0CNT       6'h14
`define TPS_OFS_STATUS      6'h18
`define TPS_BIT_CMP0        0
`define TPS_BIT_OVF0        1
`define TPS_BIT_PSR_SHARED  0
`define TPS_BIT_PSR_ASYNC   1
`define TPS_BIT_SYNC_HOLD   7
`define TPS_BIT_COMPAT      6
`define TPS_FLAGS_RESET     8'h00
`define TPS_CS_STOP         3'h0
`define TPS_CS_DIRECT       3'h1
`define TPS_CS_DIV8         3'h2
`define TPS_CS_DIV64        3'h3
`define TPS_CS_DIV256       3'h4
`define TPS_CS_DIV1024      3'h5
`define TPS_CS_EXT_FALL     3'h6
`define TPS_CS_EXT_RISE     3'h7
`define TPS_PRE_W           10
`define TPS_WGM_NORMAL      2'h0
`define TPS_WGM_PCPWM       2'h1
`define TPS_WGM_CTC         2'h2
`define TPS_WGM_FAST        2'h3
`define TPS_RESP_OKAY       2'h0
`define TPS_RESP_SLVERR     2'h2
`endif

// [tps_ext_clk_src.sv]
// External clock source model for the timer input pins
`timescale 1ns/1ps
module tps_ext_clk_src #(
  parameter int HALF_NS = 60
) (
  input  wire logic run,
  output logic      pin,
  output int        n_rise
);
  initial
  begin
    pin = 1'b0;
    n_rise = 0;
  end
  // Full periods only, so the pin rests low between bursts
  always
  begin
    wait (run);
    #7;
    while (run)
    begin
      #(HALF_NS) pin = 1'b1;
      n_rise++;
      #(HALF_NS) pin = 1'b0;
    end
  end
endmodule // tps_ext_clk_src

// [tps_timer_prescaler_properties.sv]
// Port checks for the timer prescaler
`timescale 1ns/1ps
module tps_prescaler_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_status_word_ie,
  input wire logic        ovf0_vector_ack,
  input wire logic        ovf0_irq,
  input wire logic        cmp0_irq,
  input wire logic        timer1_tick,
  input wire logic        timer3_tick,
  input wire logic        timer3_available,
  input wire logic [7:0]  timer0_count
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_cmp_irq_gate: assert property (cmp0_irq |-> cpu_status_word_ie)
    else $error("compare request without global enable");
  chk_ovf_irq_gate: assert property (ovf0_irq |-> cpu_status_word_ie)
    else $error("overflow request without global enable");
  chk_ovf_ack_clear: assert property (ovf0_vector_ack && timer0_count != 8'hff &&
    timer0_count != 8'h00 |=> !ovf0_irq)
    else $error("overflow flag kept after vector");
  chk_t3_compat_off: assert property (timer3_tick |-> timer3_available)
    else $error("timer 3 ticked while unavailable");
  chk_wr_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response late");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_reset_idle: assert property ($rose(rstn) |-> !s_axi_bvalid && !s_axi_rvalid &&
    !timer1_tick && !timer3_tick && timer0_count == 8'h00)
    else $error("outputs not idle after reset");
endmodule // tps_prescaler_chk
bind tps_timer_prescaler tps_prescaler_chk chk_u (.ref_clk, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .cpu_status_word_ie, .ovf0_vector_ack, .ovf0_irq, .cmp0_irq, .timer1_tick, .timer3_tick,
  .timer3_available, .timer0_count);

// [timer_prescaler_clock_select_flags_tb_top.sv]
// Register-level bench for the timer prescaler
`timescale 1ns/1ps
`include "tps_defines.vh"
module timer_prescaler_clock_select_flags_tb_top;
  logic        ref_clk = 1'b0, rstn = 1'b0, ie = 1'b0, run = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ovf_ack = 1'b0, cmp_ack = 1'b0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [1:0]  r;
  logic [7:0]  c1;
  wire         awready, wready, bvalid, arready, rvalid, ovf_irq, cmp_irq;
  wire         t1_tick, t3_tick, t3_av, pin;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  cnt;
  int          miscompares = 0, n_checks = 0, n_rise, t1n = 0, t3n = 0, a, b, n;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (t1_tick === 1'b1) t1n <= t1n + 1;
    if (t3_tick === 1'b1) t3n <= t3n + 1;
  end

  tps_timer_prescaler dut_u (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_timer_clock_pin0(pin), .ext_timer_clock_pin1(pin), .cpu_status_word_ie(ie),
    .ovf0_vector_ack(ovf_ack), .cmp0_vector_ack(cmp_ack), .ovf0_irq(ovf_irq),
    .cmp0_irq(cmp_irq), .timer1_tick(t1_tick), .timer3_tick(t3_tick),
    .timer3_available(t3_av), .timer0_count(cnt));
  tps_ext_clk_src src_u (.run(run), .pin(pin), .n_rise(n_rise));

  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(inout int k);
    @(posedge ref_clk);
    k++;
    if (k > 40)
    begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [31:0] v);
    int k;
    k = 0;
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      step(k);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] ad);
    int k;
    k = 0;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      step(k);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic run_t0(input logic [7:0] s);
    wr(`TPS_OFS_T0CNT, {24'h0, s});
    wr(`TPS_OFS_CSEL, 32'h1);
    c1 = cnt;
    repeat (4) @(posedge ref_clk);
    chk({24'h0, 8'(cnt - c1)}, 32'h4);
    wr(`TPS_OFS_CSEL, 32'h0);
    c1 = cnt;
    repeat (4) @(posedge ref_clk);
    chk({24'h0, cnt}, {24'h0, c1});
  endtask
  task automatic ticks(input int k, input int e1, input int e3);
    a = t1n;
    b = t3n;
    repeat (k) @(posedge ref_clk);
    chk(t1n - a, e1);
    chk(t3n - b, e3);
  endtask
  task automatic pulse(input bit ovf);
    if (ovf) ovf_ack <= 1'b1;
    else cmp_ack <= 1'b1;
    @(posedge ref_clk);
    ovf_ack <= 1'b0;
    cmp_ack <= 1'b0;
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(`TPS_OFS_FLAGS);
    chk(d, {24'h0, `TPS_FLAGS_RESET});
    rd(6'h3c);
    chk({30'h0, r}, {30'h0, `TPS_RESP_SLVERR});
    wr(6'h3c, 32'h0);
    chk({30'h0, r}, {30'h0, `TPS_RESP_SLVERR});
    wr(`TPS_OFS_T0CTRL, 32'h80);
    chk({30'h0, r}, {30'h0, `TPS_RESP_OKAY});
    wr(`TPS_OFS_MASK, 32'h3);
    ie <= 1'b1;
    run_t0(8'h7c);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h1);
    chk({31'h0, cmp_irq}, 32'h1);
    ie <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, cmp_irq}, 32'h0);
    ie <= 1'b1;
    pulse(1'b0);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h0);
    run_t0(8'hfd);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h2);
    chk({31'h0, ovf_irq}, 32'h1);
    wr(`TPS_OFS_FLAGS, 32'h0);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h2);
    pulse(1'b1);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h0);
    run_t0(8'hfd);
    wr(`TPS_OFS_FLAGS, 32'h2);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h0);
    wr(`TPS_OFS_T0CTRL, 32'h180);
    wr(`TPS_OFS_T0CNT, 32'hfd);
    wr(`TPS_OFS_CSEL, 32'h1);
    repeat (8) @(posedge ref_clk);
    wr(`TPS_OFS_CSEL, 32'h0);
    rd(`TPS_OFS_STATUS);
    chk(d & 32'h80, 32'h80);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h0);
    wr(`TPS_OFS_T0CNT, 32'h3);
    wr(`TPS_OFS_CSEL, 32'h1);
    repeat (8) @(posedge ref_clk);
    wr(`TPS_OFS_CSEL, 32'h0);
    rd(`TPS_OFS_FLAGS);
    chk(d, 32'h2);
    wr(`TPS_OFS_FLAGS, 32'h2);
    wr(`TPS_OFS_T0CTRL, 32'h80);
    wr(`TPS_OFS_CSEL, 32'h720);
    ticks(128, 16, 4);
    wr(`TPS_OFS_CSEL, 32'h320);
    ticks(128, 16, 2);
    wr(`TPS_OFS_CSEL, 32'h620);
    ticks(80, 10, 5);
    wr(`TPS_OFS_SFC, 32'h81);
    rd(`TPS_OFS_SFC);
    chk(d & 32'h83, 32'h81);
    ticks(40, 0, 0);
    wr(`TPS_OFS_SFC, 32'h0);
    rd(`TPS_OFS_SFC);
    chk(d & 32'h83, 32'h0);
    ticks(80, 10, 5);
    wr(`TPS_OFS_SFC, 32'h1);
    rd(`TPS_OFS_STATUS);
    chk(d & 32'h1f, 32'h1);
    rd(`TPS_OFS_SFC);
    chk(d & 32'h83, 32'h0);
    wr(`TPS_OFS_SFC, 32'h40);
    chk({31'h0, t3_av}, 32'h0);
    ticks(80, 10, 0);
    wr(`TPS_OFS_SFC, 32'h0);
    for (int m = 6; m < 8; m++)
    begin
      wr(`TPS_OFS_CSEL, 32'(m * 17));
      c1 = cnt;
      a = n_rise;
      b = t1n;
      run <= 1'b1;
      n = 0;
      while (pin !== 1'b1 && n < 400) #1 n++;
      if (m == 6) while (pin !== 1'b0 && n < 400) #1 n++;
      n = 0;
      while (cnt === c1 && n < 8)
      begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      chk(32'(n >= 3 && n <= 4), 32'h1);
      repeat (100) @(posedge ref_clk);
      run <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk({24'h0, 8'(cnt - c1)}, 32'(n_rise - a));
      chk(t1n - b, n_rise - a);
    end
    give_verdict();
  end
endmodule // timer_prescaler_clock_select_flags_tb_top
